// *** pct_instr_timing.sv ***
// Behaviour
// - Count execution in system clocks only.
// - No instruction exceeds eight clock cycles.
// - Not-taken branch ends one cycle sooner.
// - Most instructions: cycles equal byte count.
// - Opcodes identical to standard set; timing differs.
// - Decoder recognises 109 distinct instructions.
// - Register-operand arithmetic: one byte, one cycle.
// - Indirect RAM arithmetic: one byte, two cycles.
// - Immediate or direct accumulator ops: two, two.
// - Immediate into direct logic: three, three.
// - Direct-to-direct three/three; direct-to-register two/two.
// - Single-operand accumulator ops: one byte, one cycle.
// - Data pointer increment: one byte, one cycle.
// - Route external move to onchip, offchip, flash.
// - Flash readable by both moves, writable by external.
// - Relative offset signed, from next instruction.
// - Direct below 0x80 RAM, above special register.
`timescale 1ns/1ps
`default_nettype none

module pct_instr_timing #(
  parameter int unsigned EXT_RAM_BYTES = pct_pkg::EXT_RAM_BYTES_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic startReq,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [15:0] instrAddr,
  input wire logic branchTaken,
  input wire logic [15:0] dataPtr,
  input wire logic [7:0] ptrRegValue,
  input wire logic [7:0] extPageHigh,
  input wire logic flashExtEn,
  output logic busy_r,
  output logic done_r,
  output logic [pct_pkg::LEN_W-1:0] curLen_r,
  output logic [pct_pkg::CNT_W-1:0] curCycles_r,
  output logic [pct_pkg::CNT_W-1:0] cycleCnt_r,
  output logic condBranch_r,
  output logic taken_r,
  output logic [15:0] relTarget_r,
  output logic relValid_r,
  output logic directIsSpecial_r,
  output logic directValid_r,
  output pct_pkg::pct_route_t extRoute_r,
  output logic [15:0] extAddr_r,
  output logic extWrite_r,
  output logic codeRead_r,
  output logic flashWrite_r,
  output logic illegalOp_r
);

  // ==========================================================
  // Decode
  logic [pct_pkg::LEN_W-1:0] decLen;
  logic [pct_pkg::CNT_W-1:0] decCyc;
  logic decCond;
  logic decRel;
  logic decDirect;
  logic decExt;
  logic decExtWr;
  logic decExtWide;
  logic decCodeMove;
  logic decIllegal;

  // Opcode map matches the standard set bit for bit
  pct_opcode_decode u_decode (
    .opcode(opcode),
    .instrLen(decLen),
    .cycTaken(decCyc),
    .isCond(decCond),
    .hasRel(decRel),
    .hasDirect(decDirect),
    .isExtMove(decExt),
    .extMoveWr(decExtWr),
    .extMoveWide(decExtWide),
    .isCodeMove(decCodeMove),
    .illegal(decIllegal)
  );

  function automatic logic [15:0] relAdd(input logic [15:0] base,
                                         input logic [1:0] len,
                                         input logic [7:0] rel);
    logic [15:0] nextPc;
    nextPc = base + {14'h0000, len};
    relAdd = nextPc + {{8{rel[7]}}, rel};
  endfunction

  // ==========================================================
  // Acceptance and cycle budget
  logic accept;
  logic [pct_pkg::CNT_W-1:0] total_nxt;
  logic [15:0] extAddr_nxt;
  logic [7:0] relByte;
  pct_pkg::pct_route_t route_nxt;

  // Next instruction may be accepted in the final cycle of the current one and starts on the following clock
  assign accept = startReq && (!busy_r || done_r);
  assign total_nxt = (decCond && !branchTaken) ? 4'(decCyc - 4'h1) : decCyc;
  assign relByte = (decLen == 2'd3) ? operand2 : operand1;
  assign extAddr_nxt = decExtWide ? dataPtr : {extPageHigh, ptrRegValue};

  always_comb begin
    route_nxt = pct_pkg::ROUTE_NONE;
    if (decExt) begin
      if (flashExtEn) begin
        route_nxt = pct_pkg::ROUTE_FLASH;
      end else if ({16'h0000, extAddr_nxt} < EXT_RAM_BYTES) begin
        route_nxt = pct_pkg::ROUTE_ONCHIP;
      end else begin
        route_nxt = pct_pkg::ROUTE_OFFCHIP;
      end
    end
  end

  // ==========================================================
  // Cycle sequencer, one count per system clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cycleCnt_r <= pct_pkg::CNT_RESET;
      curCycles_r <= pct_pkg::CNT_RESET;
    end else if (accept) begin
      busy_r <= 1'b1;
      cycleCnt_r <= 4'h1;
      curCycles_r <= total_nxt;
      done_r <= (total_nxt == 4'h1);
    end else if (busy_r && !done_r) begin
      cycleCnt_r <= 4'(cycleCnt_r + 4'h1);
      done_r <= (4'(cycleCnt_r + 4'h1) == curCycles_r);
    end else begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
  end

  // ==========================================================
  // Instruction attributes, held for the whole instruction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      curLen_r <= pct_pkg::LEN_RESET;
      condBranch_r <= 1'b0;
      taken_r <= 1'b0;
      illegalOp_r <= 1'b0;
    end else if (accept) begin
      curLen_r <= decLen;
      condBranch_r <= decCond;
      taken_r <= decRel && (!decCond || branchTaken);
      illegalOp_r <= decIllegal;
    end
  end

  // ==========================================================
  // Relative target and direct address space
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      relTarget_r <= pct_pkg::ADDR_RESET;
      relValid_r <= 1'b0;
      directIsSpecial_r <= 1'b0;
      directValid_r <= 1'b0;
    end else if (accept) begin
      relTarget_r <= relAdd(instrAddr, decLen, relByte);
      relValid_r <= decRel;
      directIsSpecial_r <= decDirect && (operand1 >= pct_pkg::DIRECT_SPECIAL_BASE);
      directValid_r <= decDirect;
    end
  end

  // ==========================================================
  // Memory steering; flash is read by both moves, written by one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      extRoute_r <= pct_pkg::ROUTE_NONE;
      extAddr_r <= pct_pkg::ADDR_RESET;
      extWrite_r <= 1'b0;
      codeRead_r <= 1'b0;
      flashWrite_r <= 1'b0;
    end else if (accept) begin
      extRoute_r <= route_nxt;
      extAddr_r <= extAddr_nxt;
      extWrite_r <= decExt && decExtWr;
      codeRead_r <= decCodeMove || (decExt && !decExtWr && flashExtEn);
      flashWrite_r <= decExt && decExtWr && flashExtEn;
    end
  end

  // ==========================================================
  // Checks
  a_count_steps: assert property (@(posedge clk) disable iff (!nrst)
    (busy_r && !done_r && !accept) |=> (cycleCnt_r == 4'($past(cycleCnt_r) + 4'h1)))
    else $error("cycle count did not advance by one");

  a_max_eight: assert property (@(posedge clk) disable iff (!nrst)
    busy_r |-> (cycleCnt_r >= 4'h1 && cycleCnt_r <= 4'h8 && curCycles_r <= 4'h8))
    else $error("instruction exceeds eight cycles");

  a_not_taken_short: assert property (@(posedge clk) disable iff (!nrst)
    (accept && decCond) |=>
      (curCycles_r == ($past(branchTaken) ? $past(decCyc) : 4'($past(decCyc) - 4'h1))))
    else $error("not-taken branch length wrong");

  a_done_final: assert property (@(posedge clk) disable iff (!nrst)
    done_r |-> (busy_r && cycleCnt_r == curCycles_r))
    else $error("completion not on final cycle");

  a_reg_ops: assert property (@(posedge clk) disable iff (!nrst)
    (accept && opcode[3] && (opcode[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'he}))
      |=> (curLen_r == 2'd1 && curCycles_r == 4'h1 && done_r))
    else $error("register operand op timing wrong");

  a_indirect_ops: assert property (@(posedge clk) disable iff (!nrst)
    (accept && opcode[3:1] == 3'b011 && !opcode[7] && opcode[7:4] != 4'h7)
      |=> (curLen_r == 2'd1 && curCycles_r == 4'h2) ##1 done_r)
    else $error("indirect op timing wrong");

  a_imm_direct: assert property (@(posedge clk) disable iff (!nrst)
    (accept && opcode[3:1] == 3'b010 && (opcode[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}))
      |=> (curLen_r == 2'd2 && curCycles_r == 4'h2))
    else $error("immediate or direct op timing wrong");

  a_logic_imm_dir: assert property (@(posedge clk) disable iff (!nrst)
    (accept && (opcode inside {8'h43, 8'h53, 8'h63}))
      |=> (curLen_r == 2'd3 && !done_r) ##1 !done_r ##1 done_r)
    else $error("immediate to direct logic timing wrong");

  a_move_direct: assert property (@(posedge clk) disable iff (!nrst)
    (accept && (opcode == 8'h85 || opcode[7:3] == 5'b10101))
      |=> (curLen_r == (($past(opcode) == 8'h85) ? 2'd3 : 2'd2) && curCycles_r == 4'(curLen_r)))
    else $error("direct move timing wrong");

  a_single_acc: assert property (@(posedge clk) disable iff (!nrst)
    (accept && (opcode inside {8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4, 8'hd4, 8'ha3}))
      |=> (curLen_r == 2'd1 && done_r))
    else $error("single operand op not one cycle");

  a_route_flash: assert property (@(posedge clk) disable iff (!nrst)
    (accept && decExt && flashExtEn)
      |=> (extRoute_r == pct_pkg::ROUTE_FLASH && flashWrite_r == extWrite_r))
    else $error("flash route wrong");

  a_rel_target: assert property (@(posedge clk) disable iff (!nrst)
    (accept && decRel && decLen == 2'd2)
      |=> (relTarget_r == 16'($past(instrAddr) + 16'h0002 + {{8{$past(operand1[7])}},
                                                               $past(operand1)})))
    else $error("relative target wrong");

  a_direct_space: assert property (@(posedge clk) disable iff (!nrst)
    (accept && decDirect) |=> (directIsSpecial_r == $past(operand1[7])))
    else $error("direct space select wrong");

endmodule

`default_nettype wire

// *** pct_opcode_decode.sv ***
`timescale 1ns/1ps
`default_nettype none

module pct_opcode_decode (
  input wire logic [7:0] opcode,
  output logic [pct_pkg::LEN_W-1:0] instrLen,
  output logic [pct_pkg::CNT_W-1:0] cycTaken,
  output logic isCond,
  output logic hasRel,
  output logic hasDirect,
  output logic isExtMove,
  output logic extMoveWr,
  output logic extMoveWide,
  output logic isCodeMove,
  output logic illegal
);

  logic [3:0] hi;
  logic [3:0] lo;

  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  // ==========================================================
  // Length and cycle table, grouped by operand column
  always_comb begin
    instrLen = 2'd1;
    cycTaken = 4'd1;
    isCond = 1'b0;
    hasRel = 1'b0;
    hasDirect = 1'b0;
    isExtMove = 1'b0;
    extMoveWr = 1'b0;
    extMoveWide = 1'b0;
    isCodeMove = 1'b0;
    illegal = 1'b0;
    if (lo[3]) begin
      unique case (hi)
        4'h7: begin instrLen = 2'd2; cycTaken = 4'd2; end
        4'h8, 4'ha: begin instrLen = 2'd2; cycTaken = 4'd2; hasDirect = 1'b1; end
        4'hb: begin instrLen = 2'd3; cycTaken = 4'd4; isCond = 1'b1; hasRel = 1'b1; end
        4'hd: begin instrLen = 2'd2; cycTaken = 4'd3; isCond = 1'b1; hasRel = 1'b1; end
        default: begin instrLen = 2'd1; cycTaken = 4'd1; end
      endcase
    end else if (lo[3:1] == 3'b011) begin
      unique case (hi)
        4'h7: begin instrLen = 2'd2; cycTaken = 4'd2; end
        4'h8, 4'ha: begin instrLen = 2'd2; cycTaken = 4'd2; hasDirect = 1'b1; end
        4'hb: begin instrLen = 2'd3; cycTaken = 4'd5; isCond = 1'b1; hasRel = 1'b1; end
        default: begin instrLen = 2'd1; cycTaken = 4'd2; end
      endcase
    end else begin
      unique case (lo)
        4'h0: begin
          unique case (hi)
            4'h0: begin instrLen = 2'd1; cycTaken = 4'd1; end
            4'h1, 4'h2, 4'h3: begin
              instrLen = 2'd3; cycTaken = 4'd4; isCond = 1'b1; hasRel = 1'b1;
            end
            4'h4, 4'h5, 4'h6, 4'h7: begin
              instrLen = 2'd2; cycTaken = 4'd3; isCond = 1'b1; hasRel = 1'b1;
            end
            4'h8: begin instrLen = 2'd2; cycTaken = 4'd3; hasRel = 1'b1; end
            4'h9: begin instrLen = 2'd3; cycTaken = 4'd3; end
            4'ha, 4'hb: begin instrLen = 2'd2; cycTaken = 4'd2; end
            4'hc, 4'hd: begin instrLen = 2'd2; cycTaken = 4'd2; hasDirect = 1'b1; end
            default: begin
              cycTaken = 4'd3; isExtMove = 1'b1; extMoveWide = 1'b1; extMoveWr = hi[0];
            end
          endcase
        end
        4'h1: begin instrLen = 2'd2; cycTaken = 4'd3; end
        4'h2: begin
          unique case (hi)
            4'h0, 4'h1: begin instrLen = 2'd3; cycTaken = 4'd4; end
            4'h2, 4'h3: begin instrLen = 2'd1; cycTaken = 4'd5; end
            4'h4, 4'h5, 4'h6: begin instrLen = 2'd2; cycTaken = 4'd2; hasDirect = 1'b1; end
            4'he, 4'hf: begin cycTaken = 4'd3; isExtMove = 1'b1; extMoveWr = hi[0]; end
            default: begin instrLen = 2'd2; cycTaken = 4'd2; end
          endcase
        end
        4'h3: begin
          unique case (hi)
            4'h4, 4'h5, 4'h6: begin instrLen = 2'd3; cycTaken = 4'd3; hasDirect = 1'b1; end
            4'h7: cycTaken = 4'd3;
            4'h8, 4'h9: begin cycTaken = 4'd3; isCodeMove = 1'b1; end
            4'he, 4'hf: begin cycTaken = 4'd3; isExtMove = 1'b1; extMoveWr = hi[0]; end
            default: cycTaken = 4'd1;
          endcase
        end
        4'h4: begin
          unique case (hi)
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: begin
              instrLen = 2'd2; cycTaken = 4'd2;
            end
            4'h8: cycTaken = 4'd8;
            4'ha: cycTaken = 4'd4;
            4'hb: begin instrLen = 2'd3; cycTaken = 4'd4; isCond = 1'b1; hasRel = 1'b1; end
            default: cycTaken = 4'd1;
          endcase
        end
        default: begin
          instrLen = 2'd2;
          cycTaken = 4'd2;
          hasDirect = 1'b1;
          if (opcode == pct_pkg::OPC_RESERVED) begin
            instrLen = 2'd1;
            cycTaken = 4'd1;
            hasDirect = 1'b0;
            illegal = 1'b1;
          end else if (hi == 4'h7 || hi == 4'h8) begin
            instrLen = 2'd3;
            cycTaken = 4'd3;
          end else if (hi == 4'hb || hi == 4'hd) begin
            instrLen = 2'd3;
            cycTaken = 4'd4;
            isCond = 1'b1;
            hasRel = 1'b1;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// *** pct_pkg.sv ***
package pct_pkg;

  // ==========================================================
  // Timing limits
  localparam int unsigned MAX_CYCLES = 8;
  localparam int unsigned NUM_INSTRUCTIONS = 109;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned LEN_W = 2;

  // ==========================================================
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
  localparam logic [LEN_W-1:0] LEN_RESET = 2'h0;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // ==========================================================
  // Address space boundaries and special opcodes
  localparam logic [7:0] DIRECT_SPECIAL_BASE = 8'h80;
  localparam logic [7:0] OPC_RESERVED = 8'ha5;
  localparam int unsigned EXT_RAM_BYTES_DEFAULT = 1024;

  // ==========================================================
  // Target space of an external data move
  typedef enum logic [1:0] {
    ROUTE_NONE,
    ROUTE_ONCHIP,
    ROUTE_OFFCHIP,
    ROUTE_FLASH
  } pct_route_t;

endpackage

// *** pct_prog_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

module pct_prog_mem (
  input wire logic [15:0] addr,
  output logic [7:0] byte0,
  output logic [7:0] byte1,
  output logic [7:0] byte2
);
  // ==========================================================
  // Small program image, standard encodings
  logic [7:0] mem [0:31];

  initial begin
    mem = '{8'h28, 8'h26, 8'h24, 8'h55, 8'h25, 8'h90, 8'h43, 8'h30,
            8'h0f, 8'h85, 8'h20, 8'ha0, 8'ha8, 8'h7f, 8'he4, 8'ha3,
            8'h84, 8'h40, 8'hfe, 8'h80, 8'h05, 8'hb4, 8'h12, 8'hf0,
            8'he0, 8'hf0, 8'h93, 8'ha5, 8'he2, 8'h06, 8'h00, 8'h00};
  end

  // Outside the image the bus is not driven: show a moving pattern
  function automatic logic [7:0] rd(input logic [15:0] a);
    rd = (a < 16'h0020) ? mem[a[4:0]] : ~a[7:0];
  endfunction

  assign byte0 = rd(addr);
  assign byte1 = rd(addr + 16'h0001);
  assign byte2 = rd(addr + 16'h0002);
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk, nrst, startReq, branchTaken, flashExtEn;
  logic [15:0] instrAddr, dataPtr, relTarget_r, extAddr_r;
  logic [7:0] ptrRegValue, extPageHigh, opcode, operand1, operand2;
  logic busy_r, done_r, condBranch_r, taken_r, relValid_r, directIsSpecial_r;
  logic directValid_r, extWrite_r, codeRead_r, flashWrite_r, illegalOp_r;
  logic [pct_pkg::LEN_W-1:0] curLen_r;
  logic [pct_pkg::CNT_W-1:0] curCycles_r, cycleCnt_r;
  pct_pkg::pct_route_t extRoute_r;
  int mismatches = 0;
  int numChecks = 0;
  int cycles = 0;

  pct_prog_mem u_pct_prog_mem (.addr(instrAddr), .byte0(opcode), .byte1(operand1),
    .byte2(operand2));

  pct_instr_timing #(.EXT_RAM_BYTES(1024)) u_pct_instr_timing (.clk(clk), .nrst(nrst),
    .startReq(startReq), .opcode(opcode), .operand1(operand1), .operand2(operand2),
    .instrAddr(instrAddr), .branchTaken(branchTaken), .dataPtr(dataPtr),
    .ptrRegValue(ptrRegValue), .extPageHigh(extPageHigh), .flashExtEn(flashExtEn),
    .busy_r(busy_r), .done_r(done_r), .curLen_r(curLen_r), .curCycles_r(curCycles_r),
    .cycleCnt_r(cycleCnt_r), .condBranch_r(condBranch_r), .taken_r(taken_r),
    .relTarget_r(relTarget_r), .relValid_r(relValid_r),
    .directIsSpecial_r(directIsSpecial_r),
    .directValid_r(directValid_r), .extRoute_r(extRoute_r), .extAddr_r(extAddr_r),
    .extWrite_r(extWrite_r), .codeRead_r(codeRead_r), .flashWrite_r(flashWrite_r),
    .illegalOp_r(illegalOp_r));

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      mismatches++;
      summarize();
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Start at one address; returns in the done cycle, so calls run back to back
  task automatic run(input logic [15:0] a, input int len, input int cyc, input logic tk);
    int n;
    instrAddr = a;
    branchTaken = tk;
    startReq = 1'b1;
    @(posedge clk);
    #1;
    if (done_r !== 1'b1) startReq = 1'b0;
    n = 1;
    while (done_r !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(curLen_r), 16'(len));
    chk(16'(curCycles_r), 16'(cyc));
    chk(16'(n), 16'(cyc));
    chk(16'(cycleCnt_r), 16'(cyc));
  endtask

  task automatic rt(input pct_pkg::pct_route_t r, input logic [15:0] a);
    chk(16'(extRoute_r), 16'(r));
    chk(extAddr_r, a);
  endtask

  task automatic idle();
    startReq = 1'b0;
    @(posedge clk);
    #1;
    chk(16'(busy_r), 16'h0000);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_table();
    run(16'h0000, 1, 1, 1'b0);
    run(16'h0001, 1, 2, 1'b0);
    run(16'h001d, 1, 2, 1'b0);
    run(16'h0002, 2, 2, 1'b0);
    run(16'h0004, 2, 2, 1'b0);
    run(16'h0006, 3, 3, 1'b0);
    run(16'h0009, 3, 3, 1'b0);
    run(16'h000c, 2, 2, 1'b0);
    run(16'h000e, 1, 1, 1'b0);
    run(16'h000f, 1, 1, 1'b0);
    run(16'h0010, 1, 8, 1'b0);
    run(16'h001b, 1, 1, 1'b0);
    chk(16'(illegalOp_r), 16'h0001);
    idle();
    $display("test table done");
  endtask

  task automatic t_branch();
    run(16'h0011, 2, 3, 1'b1);
    chk(relTarget_r, 16'h0011);
    chk(16'(taken_r), 16'h0001);
    run(16'h0011, 2, 2, 1'b0);
    chk(16'({condBranch_r, taken_r, relValid_r}), 16'h0005);
    run(16'h0013, 2, 3, 1'b0);
    chk(relTarget_r, 16'h001a);
    run(16'h0015, 3, 4, 1'b1);
    chk(relTarget_r, 16'h0008);
    run(16'h0015, 3, 3, 1'b0);
    idle();
    $display("test branch done");
  endtask

  task automatic t_direct();
    run(16'h0004, 2, 2, 1'b0);
    chk(16'({directValid_r, directIsSpecial_r}), 16'h0003);
    run(16'h000c, 2, 2, 1'b0);
    chk(16'({directValid_r, directIsSpecial_r}), 16'h0002);
    run(16'h0009, 3, 3, 1'b0);
    chk(16'({directValid_r, directIsSpecial_r}), 16'h0002);
    run(16'h0000, 1, 1, 1'b0);
    chk(16'(directValid_r), 16'h0000);
    idle();
    $display("test direct done");
  endtask

  task automatic t_extmove();
    dataPtr = 16'h03ff;
    run(16'h0018, 1, 3, 1'b0);
    rt(pct_pkg::ROUTE_ONCHIP, 16'h03ff);
    dataPtr = 16'h0400;
    run(16'h0019, 1, 3, 1'b0);
    rt(pct_pkg::ROUTE_OFFCHIP, 16'h0400);
    chk(16'(extWrite_r), 16'h0001);
    run(16'h001c, 1, 3, 1'b0);
    rt(pct_pkg::ROUTE_OFFCHIP, 16'h0533);
    run(16'h001a, 1, 3, 1'b0);
    chk(16'(codeRead_r), 16'h0001);
    flashExtEn = 1'b1;
    run(16'h0018, 1, 3, 1'b0);
    chk(16'({codeRead_r, flashWrite_r}), 16'h0002);
    run(16'h0019, 1, 3, 1'b0);
    rt(pct_pkg::ROUTE_FLASH, 16'h0400);
    chk(16'(flashWrite_r), 16'h0001);
    idle();
    flashExtEn = 1'b0;
    $display("test external move done");
  endtask

  // Request held and changed while busy must be ignored
  task automatic t_refuse();
    instrAddr = 16'h0010;
    startReq = 1'b1;
    @(posedge clk);
    #1;
    instrAddr = 16'h000e;
    repeat (6) @(posedge clk);
    #1;
    chk(16'({done_r, curCycles_r}), 16'h0008);
    @(posedge clk);
    #1;
    chk(16'({done_r, cycleCnt_r}), 16'h0018);
    @(posedge clk);
    #1;
    chk(16'({done_r, curCycles_r}), 16'h0011);
    idle();
    $display("test refuse done");
  endtask

  // Reset in mid-instruction abandons it; the next request starts clean
  task automatic t_reset();
    instrAddr = 16'h0010;
    startReq = 1'b1;
    @(posedge clk);
    #1;
    startReq = 1'b0;
    @(posedge clk);
    #1;
    nrst = 1'b0;
    #1;
    chk(16'({busy_r, done_r, cycleCnt_r, curCycles_r}), 16'h0000);
    @(posedge clk);
    #1;
    nrst = 1'b1;
    run(16'h0002, 2, 2, 1'b0);
    idle();
    $display("test reset done");
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    startReq = 1'b0;
    branchTaken = 1'b0;
    flashExtEn = 1'b0;
    instrAddr = 16'h0000;
    dataPtr = 16'h0000;
    ptrRegValue = 8'h33;
    extPageHigh = 8'h05;
    repeat (3) @(posedge clk);
    #1;
    chk(16'({busy_r, done_r, extRoute_r}), 16'h0000);
    nrst = 1'b1;
    t_table();
    t_branch();
    t_direct();
    t_extmove();
    t_refuse();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
